// ===== dma_agent.sv
// Purpose: model of the DMA engine working beside the idle controller
// Assumes: bench pulses go for one cycle with the transfer length
// Notes: the transfer only advances while its clock gate is open
`timescale 1ns/1ps
module dma_agent (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic go,
  input wire logic [7:0] len,
  // Gate from the controller
  input wire logic clk_en,
  // Activity seen by the controller
  output logic busy
);
  // Cycles left in the transfer
  logic [7:0] cnt_q;
  // ----------------------------------------------------------------
  // Transfer counter
  // ----------------------------------------------------------------
  // A gated clock freezes the count, as a real engine would stall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 8'h00;
    else if (go)
      cnt_q <= len;
    else if (clk_en && cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  // Busy for the whole transfer, also seen by memory i/f
  assign busy = (cnt_q != 8'h00);
endmodule

// ===== idle_wake_pkg.sv
// Purpose: types for the idle and wake-up controller
// Assumes: nothing
// Notes: Gray coded sequencer states
package idle_wake_pkg;
  // Sequencer states, Gray along the usual path
  typedef enum logic [1:0]
  {
    ST_RUN = 2'h0,
    ST_DRAIN = 2'h1,
    ST_IDLE = 2'h3,
    ST_SETTLE = 2'h2
  } seq_state_t;
endpackage

// ===== idle_wake_regs.svh
// Purpose: register offsets, field positions, reset values and timing
// Assumes: APB byte addresses are four times the register index
// Notes: definitions only
`ifndef IDLE_WAKE_REGS_SVH
`define IDLE_WAKE_REGS_SVH
// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define IDX_CONFIG 16'h0001
`define IDX_STATUS 16'h0002
`define IDX_PCTRL 16'h9400
`define IDX_PSTAT 16'h9401
`define IDX_MCTRL 16'h9402
`define IDX_MSTAT 16'h9403
`define IDX_PLLCS 16'h9404
`define IDX_WAKEN 16'h9405
`define IDX_XBSEL 16'h9406
`define IDX_IRQEN 16'h9407
`define ADDR_W 18
`define BYTE_ADDR(i) ({i, 2'h0})
// ----------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------
`define CFG_CPU 0
`define CFG_MP 1
`define CFG_ICACHE 2
`define CFG_PERIPH_DOMAIN_IDLE_BIT 3
`define CFG_CLK 4
`define CFG_EXT_MEMORY_INTERFACE 5
`define CFG_XPORT 6
`define CFG_MPORT 7
`define CFG_IPORT 8
`define CFG_CLKE 9
`define CFG_MASK 16'h03FF
// Companions needed with clock generator idle
`define CFG_CLK_NEED 16'h01E7
// ----------------------------------------------------------------
// Other fields
// ----------------------------------------------------------------
`define MP_DMA 0
`define MP_HPI 1
`define PER_SP0 0
`define PER_SP2 2
`define PER_UART 3
`define PER_EXT_MEMORY_INTERFACE 4
`define PLL_PWRDN 0
`define PLL_RST 1
`define PLL_OSCPD 2
`define PLL_SEL 3
`define PLL_LOCK 4
`define XB_SP2 0
`define XB_UART 1
`define XB_EXT_MEMORY_INTERFACE 2
`define WK_NMI 4
`define ZERO16 16'h0000
// Oscillator settle time in reference cycles
`define OSC_SETTLE_CYC 41032
`endif

// ===== idle_wakeup_domain_ctrl.sv
// Purpose: clock domain idle entry and wake-up control behind APB
// Assumes: cpu idle strobe is one pclk cycle, pins are asynchronous
// Notes: gate outputs are high while the domain clock runs
// Operation
// [R1] Clock divider idles at once on instruction
// [R2] PLL and oscillator power down if armed
// [R3] Memory interface idles after DMA finishes
// [R4] Reset makes every domain active; code keeps muxed SP2, UART and memory i/f gated until selected
// [R5] CPU wakes on NMI or enabled irq
// [R6] Memory interface wakes with the CPU
// [R7] Clear master bit, idle wakes DMA+host
// [R8] Master control zero wakes one module
// [R9] Clear periph bit, idle wakes peripherals
// [R10] Periph control zero wakes that peripheral
// [R11] Zero config plus idle enables clocks
// [R12] Software clears PLL bits, polls lock
// [R13] PLL select one sources clocks from PLL
// [R14] Wake enables select pins for deep idle
// [R15] Count oscillator settle after wake/reset
// [R16] Software clears oscillator power-down too
// [R17] Status copies config only on instruction
// [R18] Interrupt wake clears cpu/clock status bits
// [R19] Deepest idle wakes on external irq only; code also wakes it on NMI if WK_NMI is enabled
// [R20] Serial transfer auto-wakes serial and DMA
// [R21] Unselected muxed modules gated, access errors
// [R22] Register writes only arm idle
// [R23] Clock idle without companions: bus error
// [R24] Clock idle needs both clock bits
// [R25] Strobe samples, gates update next clock
`timescale 1ns/1ps
`include "idle_wake_regs.svh"
module idle_wakeup_domain_ctrl #(
  parameter int SETTLE_CYC = `OSC_SETTLE_CYC,
  parameter int NPER = 16
)(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU events
  input wire logic idle_instr,
  input wire logic [15:0] cpu_irq,
  input wire logic muxed_access,
  input wire logic [2:0] muxed_which,
  // Pins, asynchronous
  input wire logic nmi_n,
  input wire logic [3:0] ext_irq,
  input wire logic pll_lock_pin,
  // Activity from gated modules
  input wire logic dma_busy,
  input wire logic ext_memory_interface_busy,
  input wire logic sp_xfer_req,
  // Domain gates and power
  output logic cpu_clk_en,
  output logic clkgen_en,
  output logic master_port_en,
  output logic icache_en,
  output logic xport_en,
  output logic mport_en,
  output logic iport_en,
  output logic dma_clk_en,
  output logic hpi_clk_en,
  output logic [NPER-1:0] periph_clk_en,
  output logic pll_pwrdn,
  output logic osc_pwrdn,
  output logic pll_sourced,
  output logic cpu_run,
  output logic bus_err_irq
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (NPER != 16 || SETTLE_CYC < 1 || SETTLE_CYC > 65535)
  begin : g_chk
    $error("unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1_q; // First stage, read only by second
  logic [5:0] sync2_q; // Usable pin levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Idle levels, so no false NMI right after reset
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end
    else
    begin
      sync1_q <= {pll_lock_pin, ext_irq, ~nmi_n};
      sync2_q <= sync1_q;
    end
  end
  wire nmi_s = sync2_q[0];
  wire [3:0] ext_s = sync2_q[4:1];
  wire lock_s = sync2_q[5];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] cfg_q; // Armed domain idle settings
  logic [15:0] stat_q; // Domains currently idle
  logic [15:0] pctl_q; // Armed peripheral idles
  logic [15:0] pst_q; // Peripherals idle
  logic [15:0] mctl_q; // Armed master idles
  logic [15:0] mst_q; // Master modules idle
  logic [15:0] pll_q; // PLL power and select bits
  logic [15:0] wake_source_enable_reg_q; // Deep idle wake sources
  logic [15:0] xbs_q; // Muxed module select
  logic [15:0] irqen_q; // Interrupt enables (both halves)
  logic [15:0] cnt_q; // Settle countdown
  logic err_q; // Bus error interrupt pulse
  idle_wake_pkg::seq_state_t st_q;
  idle_wake_pkg::seq_state_t st_d;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [`ADDR_W-1:0] a = paddr;
  wire h_cfg = a == `BYTE_ADDR(`IDX_CONFIG);
  wire h_st = a == `BYTE_ADDR(`IDX_STATUS);
  wire h_pc = a == `BYTE_ADDR(`IDX_PCTRL);
  wire h_ps = a == `BYTE_ADDR(`IDX_PSTAT);
  wire h_mc = a == `BYTE_ADDR(`IDX_MCTRL);
  wire h_ms = a == `BYTE_ADDR(`IDX_MSTAT);
  wire h_pl = a == `BYTE_ADDR(`IDX_PLLCS);
  wire h_wk = a == `BYTE_ADDR(`IDX_WAKEN);
  wire h_xb = a == `BYTE_ADDR(`IDX_XBSEL);
  wire h_ie = a == `BYTE_ADDR(`IDX_IRQEN);
  wire hit = h_cfg | h_st | h_pc | h_ps | h_mc | h_ms | h_pl | h_wk
    | h_xb | h_ie;
  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  wire [15:0] pll_rd = {pll_q[15:5], lock_s, pll_q[3:0]};
  wire [15:0] rd16 = h_cfg ? cfg_q : h_st ? stat_q : h_pc ? pctl_q
    : h_ps ? pst_q : h_mc ? mctl_q : h_ms ? mst_q : h_pl ? pll_rd
    : h_wk ? wake_source_enable_reg_q : h_xb ? xbs_q : h_ie ? irqen_q : `ZERO16;
  assign prdata = {16'h0000, rd16};

  // ----------------------------------------------------------------
  // Idle instruction decode
  // ----------------------------------------------------------------
  wire clk_req = cfg_q[`CFG_CLK] | cfg_q[`CFG_CLKE];
  // Both clock bits must be set, with all companions
  wire cfg_bad = clk_req &&
    ((cfg_q & `CFG_CLK_NEED) != `CFG_CLK_NEED
     || !cfg_q[`CFG_CLKE] || !cfg_q[`CFG_CLK]); // see [R24]
  wire take = idle_instr && st_q == idle_wake_pkg::ST_RUN; // see [R25]
  wire take_ok = take && !cfg_bad;
  // Muxed module access while deselected
  wire mux_err = muxed_access && |(muxed_which & ~xbs_q[2:0]);

  // Wake conditions
  wire [3:0] ext_en = ext_s & irqen_q[3:0];
  wire cpu_wake = nmi_s || |(cpu_irq & irqen_q); // see [R5]
  wire deep_wake = (nmi_s && wake_source_enable_reg_q[`WK_NMI])
    || |(ext_en & wake_source_enable_reg_q[3:0]); // see [R14] see [R19]
  wire clk_off = stat_q[`CFG_CLK];
  wire wake = clk_off ? deep_wake : cpu_wake; // see [R18]
  wire ext_memory_interface_wait = cfg_q[`CFG_EXT_MEMORY_INTERFACE] && dma_busy;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      idle_wake_pkg::ST_RUN:
        if (take_ok && cfg_q[`CFG_CPU])
          st_d = ext_memory_interface_wait ? idle_wake_pkg::ST_DRAIN
            : idle_wake_pkg::ST_IDLE;
      idle_wake_pkg::ST_DRAIN:
        if (!dma_busy)
          st_d = idle_wake_pkg::ST_IDLE; // see [R3]
      idle_wake_pkg::ST_IDLE:
        if (wake)
          st_d = stat_q[`CFG_CLK] && pll_q[`PLL_OSCPD]
            ? idle_wake_pkg::ST_SETTLE : idle_wake_pkg::ST_RUN;
      idle_wake_pkg::ST_SETTLE:
        if (cnt_q == 16'h0001)
          st_d = idle_wake_pkg::ST_RUN; // see [R15]
      default:
        st_d = idle_wake_pkg::ST_RUN;
    endcase
  end

  // Reset also counts the settle period before running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= idle_wake_pkg::ST_SETTLE; // see [R15]
      cnt_q <= 16'hFFFF;
    end
    else
    begin
      st_q <= st_d;
      if (st_q != idle_wake_pkg::ST_SETTLE)
        cnt_q <= 16'(SETTLE_CYC);
      else if (cnt_q == 16'hFFFF)
        cnt_q <= 16'(SETTLE_CYC - 1);
      else
        cnt_q <= cnt_q - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Writes only arm; status follows on the instruction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= `ZERO16; // see [R4] see [R19]
      pctl_q <= `ZERO16;
      mctl_q <= `ZERO16;
      pll_q <= `ZERO16;
      wake_source_enable_reg_q <= `ZERO16;
      xbs_q <= `ZERO16;
      irqen_q <= `ZERO16;
    end
    else
    begin
      if (wr && h_cfg)
        cfg_q <= pwdata[15:0] & `CFG_MASK; // see [R22]
      if (wr && h_pc)
        pctl_q <= pwdata[15:0];
      if (wr && h_mc)
        mctl_q <= pwdata[15:0];
      if (wr && h_pl)
        pll_q <= {11'h000, 1'b0, pwdata[3:0]}; // see [R12] see [R16]
      if (wr && h_wk)
        wake_source_enable_reg_q <= pwdata[15:0];
      if (wr && h_xb)
        xbs_q <= pwdata[15:0];
      if (wr && h_ie)
        irqen_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Idle status registers
  // ----------------------------------------------------------------
  // Auto-wake of serial port and DMA on external transfer
  wire sp_auto = pst_q[`PER_SP0] && mst_q[`MP_DMA]
    && !stat_q[`CFG_CLK] && !pll_q[`PLL_PWRDN] && sp_xfer_req;
  wire waking = st_q == idle_wake_pkg::ST_IDLE && wake;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= `ZERO16; // see [R4]
      pst_q <= `ZERO16;
      mst_q <= `ZERO16;
    end
    else
    begin
      if (take_ok)
      begin
        // Copy armed settings; EXT_MEMORY_INTERFACE waits for DMA in drain
        stat_q <= cfg_q; // see [R17] see [R1] see [R11]
        pst_q <= cfg_q[`CFG_PERIPH_DOMAIN_IDLE_BIT] ? pctl_q : `ZERO16; // see [R9]
        mst_q <= cfg_q[`CFG_MP] ? mctl_q : `ZERO16; // see [R7]
      end
      else
      begin
        if (waking)
        begin
          // Clear cpu, clock, memory interface, xport and iport status; mport and config kept
          stat_q[`CFG_CPU] <= 1'b0; // see [R18]
          stat_q[`CFG_CLK] <= 1'b0;
          stat_q[`CFG_CLKE] <= 1'b0;
          stat_q[`CFG_EXT_MEMORY_INTERFACE] <= 1'b0; // see [R6]
          stat_q[`CFG_XPORT] <= 1'b0;
          stat_q[`CFG_IPORT] <= 1'b0;
          pst_q[`PER_EXT_MEMORY_INTERFACE] <= 1'b0; // see [R6]
        end
        else
          pst_q <= pst_q & pctl_q; // see [R10]
        mst_q <= mst_q & mctl_q; // see [R8]
      end
    end
  end

  // Bus error on bad clock idle or gated module access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_q <= 1'b0;
    else
      err_q <= (take && cfg_bad) || mux_err; // see [R23] see [R21]
  end

  // ----------------------------------------------------------------
  // Gate outputs
  // ----------------------------------------------------------------
  wire drain = st_q == idle_wake_pkg::ST_DRAIN;
  wire ext_memory_interface_off = stat_q[`CFG_EXT_MEMORY_INTERFACE] && !drain && !ext_memory_interface_busy;
  assign cpu_clk_en = !stat_q[`CFG_CPU];
  assign clkgen_en = !stat_q[`CFG_CLK]; // see [R1]
  assign master_port_en = !stat_q[`CFG_MP];
  assign icache_en = !stat_q[`CFG_ICACHE];
  assign xport_en = !stat_q[`CFG_XPORT];
  assign mport_en = !stat_q[`CFG_MPORT];
  assign iport_en = !stat_q[`CFG_IPORT];
  assign dma_clk_en = !mst_q[`MP_DMA] || sp_auto; // see [R20]
  assign hpi_clk_en = !mst_q[`MP_HPI];
  genvar gi;
  for (gi = 0; gi < NPER; gi++)
  begin : g_per
    wire sel_ok = gi == `PER_SP2 ? xbs_q[`XB_SP2]
      : gi == `PER_UART ? xbs_q[`XB_UART]
      : gi == `PER_EXT_MEMORY_INTERFACE ? xbs_q[`XB_EXT_MEMORY_INTERFACE] : 1'b1;
    wire idle_b = gi == `PER_EXT_MEMORY_INTERFACE ? (pst_q[gi] && !ext_memory_interface_busy)
      || ext_memory_interface_off : pst_q[gi];
    wire auto_b = gi == `PER_SP0 && sp_auto;
    assign periph_clk_en[gi] = sel_ok && (!idle_b || auto_b); // see [R21]
  end
  // Power-down only while the clock generator is idle and the bit is armed
  assign pll_pwrdn = stat_q[`CFG_CLK] && pll_q[`PLL_PWRDN]; // see [R2]
  assign osc_pwrdn = stat_q[`CFG_CLK] && pll_q[`PLL_OSCPD]; // see [R2]
  assign pll_sourced = pll_q[`PLL_SEL] && lock_s; // see [R13]
  assign cpu_run = st_q == idle_wake_pkg::ST_RUN && !stat_q[`CFG_CPU];
  assign bus_err_irq = err_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  status_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    take_ok |=> stat_q == $past(cfg_q)) // see [R17]
    else $error("status not copied on idle instruction");
  status_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!take && !waking) |=> stat_q == $past(stat_q)) // see [R22]
    else $error("status changed without instruction or wake");
  bad_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (take && cfg_bad) |=> bus_err_irq && stat_q == $past(stat_q)) // see [R23]
    else $error("bad clock idle not flagged");
  wake_cpu_a: assert property (@(posedge pclk) disable iff (!presetn)
    (waking && !clk_off) |=> cpu_clk_en && st_q == idle_wake_pkg::ST_RUN) // see [R5]
    else $error("cpu did not wake");
  ext_memory_interface_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    waking |=> !pst_q[`PER_EXT_MEMORY_INTERFACE] && !stat_q[`CFG_EXT_MEMORY_INTERFACE]) // see [R6]
    else $error("memory interface stayed idle");
  master_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!take && !mctl_q[`MP_DMA]) |=> dma_clk_en) // see [R8]
    else $error("dma not woken");
  drain_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == idle_wake_pkg::ST_DRAIN && dma_busy) |=>
    st_q == idle_wake_pkg::ST_DRAIN) // see [R3]
    else $error("drain left while dma busy");
  pll_down_a: assert property (@(posedge pclk) disable iff (!presetn)
    pll_pwrdn |-> !clkgen_en && pll_q[`PLL_PWRDN]) // see [R2]
    else $error("pll powered down without request");
  gated_mux_a: assert property (@(posedge pclk) disable iff (!presetn)
    !xbs_q[`XB_UART] |-> !periph_clk_en[`PER_UART]) // see [R21]
    else $error("deselected module clock running");
  settle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == idle_wake_pkg::ST_SETTLE && cnt_q > 16'h0001 &&
     cnt_q != 16'hFFFF) |=> !cpu_run) // see [R15]
    else $error("cpu ran during oscillator settle");
endmodule

// ===== tb.sv
// Purpose: self-checking bench for the idle and wake-up controller
// Assumes: APB answers with no wait, settle count shortened to 8
// Notes: bus error pulses are counted by a monitor, not polled
`timescale 1ns/1ps
`include "idle_wake_regs.svh"
module tb;
  localparam int SETTLE = 8;
  // Bench driven inputs
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, idle_instr = 1'h0, muxed_access = 1'h0;
  logic nmi_n = 1'h1, pll_lock_pin = 1'h0, dma_go = 1'h0, sp_req = 1'h0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000, r;
  logic [15:0] cpu_irq = 16'h0000;
  logic [2:0] muxed_which = 3'h0;
  logic [3:0] ext_irq = 4'h0;
  // Design outputs
  logic [31:0] prdata;
  logic [15:0] periph_clk_en;
  logic pready, pslverr, cpu_clk_en, clkgen_en, master_port_en, dma_busy;
  logic icache_en, xport_en, mport_en, iport_en, dma_clk_en, hpi_clk_en;
  logic pll_pwrdn, osc_pwrdn, pll_sourced, cpu_run, bus_err_irq, e;
  int mismatches = 0, n_checks = 0, berr = 0, b;
  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  always #20 pclk = ~pclk;
  idle_wakeup_domain_ctrl #(.SETTLE_CYC(SETTLE)) idle_wakeup_domain_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_instr(idle_instr),
    .cpu_irq(cpu_irq), .muxed_access(muxed_access), .nmi_n(nmi_n),
    .muxed_which(muxed_which), .ext_irq(ext_irq), .dma_busy(dma_busy),
    .pll_lock_pin(pll_lock_pin), .ext_memory_interface_busy(dma_busy), .sp_xfer_req(sp_req),
    .cpu_clk_en(cpu_clk_en), .clkgen_en(clkgen_en), .icache_en(icache_en),
    .master_port_en(master_port_en), .xport_en(xport_en), .mport_en(mport_en),
    .iport_en(iport_en), .dma_clk_en(dma_clk_en), .hpi_clk_en(hpi_clk_en),
    .periph_clk_en(periph_clk_en), .pll_pwrdn(pll_pwrdn), .cpu_run(cpu_run),
    .osc_pwrdn(osc_pwrdn), .pll_sourced(pll_sourced), .bus_err_irq(bus_err_irq));
  dma_agent dma_agent_i (.clk(pclk), .rst_n(presetn), .go(dma_go),
    .len(8'h0C), .clk_en(dma_clk_en), .busy(dma_busy));
  // Bus error is a one-cycle pulse, so count it at every edge
  always @(posedge pclk)
  begin
    if (bus_err_irq === 1'h1)
      berr++;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= `BYTE_ADDR(idx);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    apb(1'h1, idx, {16'h0000, d});
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [15:0] exp);
    apb(1'h0, idx, 32'h00000000);
    chk(r, {16'h0000, exp});
  endtask
  // Idle instruction pulse, once the cpu is running or after 40 cycles of waiting
  task automatic idle();
    repeat (40) if (cpu_run !== 1'h1) @(posedge pclk);
    @(posedge pclk);
    idle_instr <= 1'h1;
    @(posedge pclk);
    idle_instr <= 1'h0;
    @(posedge pclk);
    #1;
  endtask
  task automatic muxed(input logic [2:0] w);
    @(posedge pclk);
    muxed_access <= 1'h1;
    muxed_which <= w;
    @(posedge pclk);
    muxed_access <= 1'h0;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (SETTLE - 3) @(posedge pclk);
    #1;
    chk(cpu_run, 1'h0);
    chk({cpu_clk_en, clkgen_en, master_port_en, pll_pwrdn}, 4'hE);
    chk({dma_clk_en, hpi_clk_en, osc_pwrdn, pll_sourced}, 4'hC);
    chk(periph_clk_en & 16'hFFE3, 16'hFFE3);
    repeat (20) if (cpu_run !== 1'h1) @(posedge pclk);
    chk(cpu_run, 1'h1);
    rdc(`IDX_CONFIG, 16'h0000);
    rdc(`IDX_STATUS, 16'h0000);
    apb(1'h0, 16'h0003, 32'h00000000);
    chk(e, 1'h1);
    chk(r, 32'h00000000);
    $display("reset test done");
  endtask
  task automatic t_master();
    wr(`IDX_CONFIG, 16'h0002);
    wr(`IDX_MCTRL, 16'h0003);
    chk(master_port_en, 1'h1);
    rdc(`IDX_STATUS, 16'h0000);
    idle();
    chk({master_port_en, dma_clk_en, hpi_clk_en}, 3'h0);
    rdc(`IDX_STATUS, 16'h0002);
    wr(`IDX_MCTRL, 16'h0001);
    repeat (2) @(posedge pclk);
    #1;
    chk({dma_clk_en, hpi_clk_en}, 2'h1);
    wr(`IDX_CONFIG, 16'h0000);
    idle();
    chk({master_port_en, dma_clk_en, hpi_clk_en}, 3'h7);
    wr(`IDX_MCTRL, 16'h0000);
    $display("master port test done");
  endtask
  task automatic t_periph();
    wr(`IDX_XBSEL, 16'h0004);
    wr(`IDX_PCTRL, 16'h0011);
    wr(`IDX_CONFIG, 16'h0008);
    idle();
    chk({periph_clk_en[4], periph_clk_en[0]}, 2'h0);
    wr(`IDX_PCTRL, 16'h0001);
    repeat (2) @(posedge pclk);
    #1;
    chk({periph_clk_en[4], periph_clk_en[0]}, 2'h2);
    wr(`IDX_CONFIG, 16'h0000);
    idle();
    chk(periph_clk_en[0], 1'h1);
    wr(`IDX_PCTRL, 16'h0000);
    b = berr;
    muxed(3'h4);
    chk(berr - b, 0);
    wr(`IDX_XBSEL, 16'h0000);
    muxed(3'h4);
    chk(berr - b, 1);
    chk(periph_clk_en[4], 1'h0);
    $display("peripheral test done");
  endtask
  task automatic t_clkerr();
    b = berr;
    wr(`IDX_CONFIG, 16'h0010);
    idle();
    repeat (2) @(posedge pclk);
    chk(berr - b, 1);
    chk(clkgen_en, 1'h1);
    rdc(`IDX_STATUS, 16'h0000);
    wr(`IDX_CONFIG, 16'h0000);
    $display("clock error test done");
  endtask
  task automatic t_cpu();
    wr(`IDX_IRQEN, 16'h0001);
    wr(`IDX_CONFIG, 16'h0021);
    idle();
    chk({cpu_clk_en, cpu_run}, 2'h0);
    cpu_irq <= 16'h0002;
    repeat (8) @(posedge pclk);
    chk(cpu_clk_en, 1'h0);
    cpu_irq <= 16'h0001;
    repeat (20) if (cpu_clk_en !== 1'h1) @(posedge pclk);
    chk(cpu_clk_en, 1'h1);
    cpu_irq <= 16'h0000;
    rdc(`IDX_STATUS, 16'h0000);
    rdc(`IDX_CONFIG, 16'h0021);
    idle();
    nmi_n <= 1'h0;
    repeat (20) if (cpu_clk_en !== 1'h1) @(posedge pclk);
    chk(cpu_clk_en, 1'h1);
    nmi_n <= 1'h1;
    wr(`IDX_CONFIG, 16'h0000);
    $display("cpu wake test done");
  endtask
  task automatic t_deep();
    wr(`IDX_PLLCS, 16'h0005);
    wr(`IDX_WAKEN, 16'h0001);
    wr(`IDX_CONFIG, 16'h03F7);
    idle();
    chk({clkgen_en, pll_pwrdn, osc_pwrdn}, 3'h3);
    ext_irq <= 4'h2;
    repeat (8) @(posedge pclk);
    chk(clkgen_en, 1'h0);
    ext_irq <= 4'h1;
    repeat (20) if (clkgen_en !== 1'h1) @(posedge pclk);
    #1;
    chk({clkgen_en, cpu_run}, 2'h2);
    repeat (SETTLE + 10) if (cpu_run !== 1'h1) @(posedge pclk);
    chk(cpu_run, 1'h1);
    ext_irq <= 4'h0;
    rdc(`IDX_CONFIG, 16'h03F7);
    rdc(`IDX_STATUS, 16'h0086);
    wr(`IDX_CONFIG, 16'h0000);
    idle();
    rdc(`IDX_STATUS, 16'h0000);
    chk({clkgen_en, master_port_en, icache_en}, 3'h7);
    wr(`IDX_PLLCS, 16'h0000);
    pll_lock_pin <= 1'h1;
    wr(`IDX_PLLCS, 16'h0008);
    repeat (4) @(posedge pclk);
    chk(pll_sourced, 1'h1);
    $display("deep idle test done");
  endtask
  task automatic t_dma();
    wr(`IDX_XBSEL, 16'h0004);
    wr(`IDX_CONFIG, 16'h0020);
    @(posedge pclk);
    dma_go <= 1'h1;
    @(posedge pclk);
    dma_go <= 1'h0;
    idle();
    chk(periph_clk_en[4], 1'h1);
    rdc(`IDX_STATUS, 16'h0020);
    repeat (30) if (dma_busy !== 1'h0) @(posedge pclk);
    repeat (3) @(posedge pclk);
    #1;
    chk(periph_clk_en[4], 1'h0);
    // Cpu idle with a busy DMA goes through the drain state
    @(posedge pclk);
    dma_go <= 1'h1;
    @(posedge pclk);
    dma_go <= 1'h0;
    wr(`IDX_CONFIG, 16'h0021);
    idle();
    chk({periph_clk_en[4], cpu_clk_en}, 2'h2);
    repeat (30) if (dma_busy !== 1'h0) @(posedge pclk);
    repeat (3) @(posedge pclk);
    #1;
    chk(periph_clk_en[4], 1'h0);
    cpu_irq <= 16'h0001;
    repeat (20) if (cpu_clk_en !== 1'h1) @(posedge pclk);
    chk(cpu_clk_en, 1'h1);
    cpu_irq <= 16'h0000;
    wr(`IDX_CONFIG, 16'h0000);
    idle();
    // Serial transfer wakes idled serial port and DMA
    wr(`IDX_PCTRL, 16'h0001);
    wr(`IDX_MCTRL, 16'h0001);
    wr(`IDX_CONFIG, 16'h000A);
    idle();
    chk({dma_clk_en, periph_clk_en[0]}, 2'h0);
    sp_req <= 1'h1;
    @(posedge pclk);
    #1;
    chk({dma_clk_en, periph_clk_en[0]}, 2'h3);
    sp_req <= 1'h0;
    wr(`IDX_CONFIG, 16'h0000);
    idle();
    $display("dma drain test done");
  endtask
  // ----------------------------------------------------------------
  // Verdict, sequence and watchdog
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_master();
    t_periph();
    t_clkerr();
    t_cpu();
    t_deep();
    t_dma();
    final_report();
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("BAD t=%0t watchdog expired", $time);
    final_report();
  end
endmodule
